// *** ebws_pkg.sv ***
// Purpose: shared constants and types of the external bus wait-state and bank-switch block
// Assumes: 16-bit registers on a 32-bit classic Wishbone bus, one word per register
// Notes:   byte address of a register is four times its index

package ebws_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices (byte address = index * 4)
	localparam logic [7:0]  WSC_IDX        = 8'h28;
	localparam logic [7:0]  BSC_IDX        = 8'h29;
	localparam logic [7:0]  WCTL_IDX       = 8'h2b;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] WSC_RST        = 16'h7fff;
	localparam logic        MULT_RST       = 1'b0;
	localparam logic        CONSECUTIVE_SWITCH_BIT_RST     = 1'b1;
	localparam logic [1:0]  DIV_RST        = 2'h3;
	localparam logic        ACKOFF_RST     = 1'b1;
	localparam logic        HBH_RST        = 1'b0;
	localparam logic        BH_RST         = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// field positions of wait_state_config
	localparam int          WS_XPA_BIT     = 15;
	localparam int          WS_IO_LSB      = 12;
	localparam int          WS_DHI_LSB     = 9;
	localparam int          WS_DLO_LSB     = 6;
	localparam int          WS_PHI_LSB     = 3;
	localparam int          WS_PLO_LSB     = 0;
	localparam int          WS_FLD_W       = 3;

	// field positions of bank_switch_control
	localparam int          BS_CONSECUTIVE_SWITCH_BIT_BIT  = 15;
	localparam int          BS_DIV_LSB     = 13;
	localparam int          BS_ACKOFF_BIT  = 12;
	localparam int          BS_HBH_BIT     = 2;
	localparam int          BS_BH_BIT      = 1;

	// field position of wait_state_control
	localparam int          WC_MULT_BIT    = 0;

	////////////////////////////////////////////////////////////////////////////////
	// address ranges
	localparam logic [15:0] DATA_HI_BASE   = 16'h3000;
	localparam int          BANK_BIT       = 15;
	localparam int          XPA_LIMIT_BIT  = 22;

	////////////////////////////////////////////////////////////////////////////////
	// address spaces and sequencer states
	typedef enum logic [1:0] {
		SP_PROG = 2'b00,
		SP_DATA = 2'b01,
		SP_IO   = 2'b10
	} ebws_space_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_BANK   = 3'b001,
		ST_START  = 3'b010,
		ST_STROBE = 3'b011,
		ST_TRAIL  = 3'b100,
		ST_DONE   = 3'b101
	} ebws_state_t;

endpackage

// *** ebws_clkdiv.sv ***
// Purpose: output clock divider, divide by field value plus one
// Assumes: div_i comes from a register on clk_i
// Notes:   tick_o marks the last processor cycle of each output clock period

`timescale 1ns/1ps

module ebws_clkdiv
	import ebws_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic [1:0] div_i,
	// outputs
	output logic            clock_output_pin_o,
	output logic            tick_o
);

	typedef struct packed {
		logic [1:0] cnt;
		logic       clk;
	} ebws_div_t;

	ebws_div_t r;
	ebws_div_t n;

	// a shrinking divide value must not strand the counter above it
	assign tick_o = (r.cnt >= div_i);

	always_comb begin
		n = r;
		n.cnt = tick_o ? 2'h0 : 2'(r.cnt + 2'h1);
		// divide by one cannot toggle from a flop: the pin then stays high
		n.clk = (n.cnt <= (div_i >> 1));
		if (rst_i) begin
			n = '0;
			n.clk = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		r <= n;
	end

	assign clock_output_pin_o = r.clk;

endmodule

// *** ebws_top.sv ***
// Purpose: external bus wait-state generator, bank switching and bus control register
// Assumes: core holds req_i until done_o and drops it in the cycle after
// Notes:   sequencer phases advance on output clock periods
//
// Notes on behaviour
// - wait config register fully read/write, resets to 7fff
// - top bit picks which program ranges the two program fields cover
// - bits 14..12 give wait count for all I/O accesses
// - bits 11..9 give wait count for data accesses from 3000h up
// - bits 8..6 are stored and read back but never used
// - program fields: low/high 32K per page, or split at 3fffff
// - multiplier clear uses field directly, set doubles it, up to 14
// - multiplier at bit 0 of wait control register, resets zero, rest reserved
// - one extra cycle when program or data accesses cross a 32K bank
// - consecutive bit clear: extra cycles only on crossings; resets to one
// - consecutive bit set: every memory read takes start, read, trailing cycles
// - two-bit divide field sets output clock as processor clock over value plus one; at value zero the pin stays high instead
// - bit 12 enables acknowledge output-off, set at reset
// - bit 2 enables host data bus holder, cleared at reset
// - bit 1 enables external data bus holder, cleared at reset
// - keep last bank bit; on mismatch withhold strobe one output clock, update
//
// The implementer's own choice: the Wishbone slave port.

`timescale 1ns/1ps

module ebws_top
	import ebws_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// core access port
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire ebws_space_t space_i,
	input  wire logic [22:0] addr_i,
	output logic             done_o,
	output logic             busy_o,
	// external bus pins
	input  wire logic        ready_i,
	output logic [22:0]      ext_addr_o,
	output logic             ext_we_o,
	output logic             memory_strobe_n_o,
	output logic             io_strobe_n_o,
	output logic             clock_output_pin_o,
	// interrupt acknowledge and bus holders
	input  wire logic        interrupt_ack_out_n_i,
	output logic             interrupt_ack_out_n_o,
	output logic             ack_output_off_o,
	output logic             host_bus_holder_en_o,
	output logic             data_bus_holder_en_o
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0] ws;
		logic        mult;
		logic        consecutive_switch_bit;
		logic [1:0]  div;
		logic        ackoff;
		logic        host_bus_holder_en;
		logic        bh;
		ebws_state_t st;
		logic [3:0]  wcnt;
		logic [22:0] addr;
		ebws_space_t sp;
		logic        we;
		logic [8:0]  key;
		logic        key_ok;
		logic        memory_strobe_n;
		logic        iostrb_n;
		logic        interrupt_ack_out_n;
		logic        ack;
		logic [15:0] rdat;
		logic        rdy_s1;
		logic        rdy_s2;
	} ebws_core_t;

	ebws_core_t r;
	ebws_core_t n;
	logic       tick;
	logic       acc;
	logic       mem;
	logic       hop;
	logic [15:0] rv;
	logic [15:0] wv;

	////////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] idx);
		return adr[7:2] == idx[5:0];
	endfunction

	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] d,
	                                       input logic [1:0] sel);
		logic [15:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = d[7:0];
		end
		if (sel[1]) begin
			v[15:8] = d[15:8];
		end
		return v;
	endfunction

	// wait count for one access from current register values
	function automatic logic [3:0] wait_of(input logic [15:0] ws, input logic mult,
	                                       input ebws_space_t sp, input logic [22:0] a);
		logic [2:0] f;
		logic       hi;
		f  = 3'h0;
		hi = ws[WS_XPA_BIT] ? a[XPA_LIMIT_BIT] : a[BANK_BIT];
		unique case (sp)
			SP_PROG: begin
				f = hi ? ws[WS_PHI_LSB +: WS_FLD_W] : ws[WS_PLO_LSB +: WS_FLD_W];
			end
			SP_DATA: begin
				// the lower data field is stored only, no external range behind it
				f = (a[15:0] >= DATA_HI_BASE) ? ws[WS_DHI_LSB +: WS_FLD_W] : 3'h0;
			end
			SP_IO: begin
				f = ws[WS_IO_LSB +: WS_FLD_W];
			end
			default: begin
				f = 3'h0;
			end
		endcase
		return mult ? {f, 1'b0} : {1'b0, f};
	endfunction

	// program banks carry the page, so a page change is also a crossing
	function automatic logic [8:0] bank_key(input ebws_space_t sp, input logic [22:0] a);
		return (sp == SP_PROG) ? {1'b0, a[22:15]} : {1'b1, 7'h00, a[BANK_BIT]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// output clock divider

	ebws_clkdiv u_div (
		.clk_i              (clk_i),
		.rst_i              (rst_i),
		.div_i              (r.div),
		.clock_output_pin_o (clock_output_pin_o),
		.tick_o             (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	assign acc = wb_cyc_i & wb_stb_i & ~r.ack;
	assign mem = (space_i != SP_IO);
	assign hop = mem & r.key_ok & (bank_key(space_i, addr_i) != r.key);

	always_comb begin
		rv = 16'h0000;
		if (reg_hit(wb_adr_i, WSC_IDX)) begin
			rv = r.ws;
		end else if (reg_hit(wb_adr_i, BSC_IDX)) begin
			rv[BS_CONSECUTIVE_SWITCH_BIT_BIT]      = r.consecutive_switch_bit;
			rv[BS_DIV_LSB +: 2]    = r.div;
			rv[BS_ACKOFF_BIT]      = r.ackoff;
			rv[BS_HBH_BIT]         = r.host_bus_holder_en;
			rv[BS_BH_BIT]          = r.bh;
		end else if (reg_hit(wb_adr_i, WCTL_IDX)) begin
			rv[WC_MULT_BIT] = r.mult;
		end
		wv = wmerge(rv, wb_dat_i[15:0], wb_sel_i[1:0]);
	end

	always_comb begin
		n = r;
		n.rdy_s1 = ready_i;
		n.rdy_s2 = r.rdy_s1;
		// register bus: answer every address, unmapped reads as zero
		n.ack = acc;
		if (acc) begin
			n.rdat = rv;
		end
		if (acc & wb_we_i) begin
			if (reg_hit(wb_adr_i, WSC_IDX)) begin
				n.ws = wv;
			end else if (reg_hit(wb_adr_i, BSC_IDX)) begin
				n.consecutive_switch_bit = wv[BS_CONSECUTIVE_SWITCH_BIT_BIT];
				n.div    = wv[BS_DIV_LSB +: 2];
				n.ackoff = wv[BS_ACKOFF_BIT];
				n.host_bus_holder_en    = wv[BS_HBH_BIT];
				n.bh     = wv[BS_BH_BIT];
			end else if (reg_hit(wb_adr_i, WCTL_IDX)) begin
				n.mult = wv[WC_MULT_BIT];
			end
		end
		// access sequencer
		unique case (r.st)
			ST_IDLE: begin
				if (req_i) begin
					n.addr = addr_i;
					n.sp   = space_i;
					n.we   = we_i;
					n.wcnt = wait_of(r.ws, r.mult, space_i, addr_i);
					if (mem) begin
						n.key    = bank_key(space_i, addr_i);
						n.key_ok = 1'b1;
					end
					if (r.consecutive_switch_bit & ~we_i & mem) begin
						n.st = ST_START;
					end else if (hop) begin
						n.st = ST_BANK;
					end else begin
						n.st = ST_STROBE;
					end
				end
			end
			ST_BANK: begin
				if (tick) begin
					n.st = ST_STROBE;
				end
			end
			ST_START: begin
				if (tick) begin
					n.st = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (tick) begin
					if (r.wcnt != 4'h0) begin
						n.wcnt = r.wcnt - 4'h1;
					end else if (r.rdy_s2) begin
						n.st = (r.consecutive_switch_bit & ~r.we & (r.sp != SP_IO)) ? ST_TRAIL : ST_DONE;
					end
				end
			end
			ST_TRAIL: begin
				if (tick) begin
					n.st = ST_DONE;
				end
			end
			ST_DONE: begin
				n.st = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		n.memory_strobe_n  = ~((n.st == ST_STROBE) & (n.sp != SP_IO));
		n.iostrb_n = ~((n.st == ST_STROBE) & (n.sp == SP_IO));
		n.interrupt_ack_out_n   = r.ackoff | interrupt_ack_out_n_i;
		if (rst_i) begin
			n          = '0;
			n.ws       = WSC_RST;
			n.mult     = MULT_RST;
			n.consecutive_switch_bit   = CONSECUTIVE_SWITCH_BIT_RST;
			n.div      = DIV_RST;
			n.ackoff   = ACKOFF_RST;
			n.host_bus_holder_en      = HBH_RST;
			n.bh       = BH_RST;
			n.st       = ST_IDLE;
			n.sp       = SP_PROG;
			n.memory_strobe_n  = 1'b1;
			n.iostrb_n = 1'b1;
			n.interrupt_ack_out_n   = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		r <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_dat_o              = {16'h0000, r.rdat};
	assign wb_ack_o              = r.ack;
	assign done_o                = (r.st == ST_DONE);
	assign busy_o                = (r.st != ST_IDLE);
	assign ext_addr_o            = r.addr;
	assign ext_we_o              = r.we;
	assign memory_strobe_n_o     = r.memory_strobe_n;
	assign io_strobe_n_o         = r.iostrb_n;
	assign interrupt_ack_out_n_o = r.interrupt_ack_out_n;
	assign ack_output_off_o      = r.ackoff;
	assign host_bus_holder_en_o  = r.host_bus_holder_en;
	assign data_bus_holder_en_o  = r.bh;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic wrote_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wrote_r <= 1'b0;
		end else if (acc & wb_we_i) begin
			wrote_r <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wsc_reset_read_a: assert property (!wrote_r && acc && !wb_we_i && reg_hit(wb_adr_i, WSC_IDX)
		|=> wb_dat_o == 32'h00007fff) else $error("wait config reset value wrong");
	wsc_write_back_a: assert property (acc && wb_we_i && wb_sel_i[1:0] == 2'h3
		&& reg_hit(wb_adr_i, WSC_IDX) |=> r.ws == $past(wb_dat_i[15:0]))
		else $error("wait config write lost");
	wctl_reserved_a: assert property (wb_ack_o && reg_hit($past(wb_adr_i), WCTL_IDX)
		|-> wb_dat_o[31:1] == 31'h0) else $error("wait control reserved bits set");
	bsc_reserved_a: assert property (wb_ack_o && reg_hit($past(wb_adr_i), BSC_IDX)
		|-> wb_dat_o[11:3] == 9'h0 && !wb_dat_o[0]) else $error("bank reserved bits set");
	bus_ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack not a single pulse");
	wait_range_a: assert property (r.wcnt <= 4'he)
		else $error("wait count above fourteen");
	consecutive_switch_bit_start_a: assert property (r.st == ST_IDLE && req_i && r.consecutive_switch_bit && !we_i && mem
		|=> r.st == ST_START) else $error("consecutive read skipped start");
	bank_cross_a: assert property (r.st == ST_IDLE && req_i && !r.consecutive_switch_bit && hop
		|=> r.st == ST_BANK && memory_strobe_n_o) else $error("bank crossing missed");
	same_bank_a: assert property (r.st == ST_IDLE && req_i && !r.consecutive_switch_bit && !hop
		|=> r.st == ST_STROBE) else $error("needless extra cycle");
	wait_hold_a: assert property (r.st == ST_STROBE && r.wcnt != 4'h0
		|=> r.st == ST_STROBE) else $error("strobe ended during waits");
	ready_ext_a: assert property (r.st == ST_STROBE && r.wcnt == 4'h0 && !r.rdy_s2
		|=> r.st == ST_STROBE) else $error("not ready ignored");
	interrupt_ack_out_off_a: assert property (r.ackoff |=> interrupt_ack_out_n_o)
		else $error("acknowledge driven while off");

	consecutive_switch_bit_read_c: cover property (r.st == ST_TRAIL ##[1:40] done_o);
	bank_switch_c: cover property (r.st == ST_BANK ##[1:8] r.st == ST_STROBE);
	ready_wait_c:  cover property (r.st == ST_STROBE && r.wcnt == 4'h0 && !r.rdy_s2 && tick);
	double_wait_c: cover property (r.mult && r.st == ST_STROBE && r.wcnt == 4'he);

endmodule

// *** ebws_mem_model.sv ***
// Purpose: model of a slow external memory or i/o part answering with ready
// Assumes: strobes active low, one access at a time
// Notes:   with a stall set, ready stays low while unselected, no kinder than a real part

`timescale 1ns/1ps

module ebws_mem_model (
	// clock
	input  wire logic       clk_i,
	// strobes from the block
	input  wire logic       mem_sel_n_i,
	input  wire logic       io_sel_n_i,
	// cycles from a strobe falling until ready rises, counted over the programmed waits too
	input  wire logic [3:0] stall_i,
	// ready pin
	output logic            ready_o
);
	logic [3:0] cnt_r;

	always_ff @(posedge clk_i) begin
		if (mem_sel_n_i && io_sel_n_i)
			cnt_r <= 4'h0;
		else if (cnt_r != 4'hf)
			cnt_r <= cnt_r + 4'h1;
	end

	// slow part holds ready low until its own time has run out
	assign ready_o = (stall_i == 4'h0) || (cnt_r >= stall_i);
endmodule

// *** tb_ebws_top.sv ***
// Purpose: self-checking bench for the wait-state and bank-switch block
// Assumes: master waits for ack; core drops req at the edge that shows done
// Notes:   wait counts judged as cycle differences, so fixed pipeline delays cancel

`timescale 1ns/1ps

module tb_ebws_top
	import ebws_pkg::*;
;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, stall;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        req_i, we_i, done_o, busy_o, ready_i, ext_we_o, interrupt_ack_out_n_i;
	ebws_space_t space_i;
	logic [22:0] addr_i, ext_addr_o;
	logic        memory_strobe_n_o, io_strobe_n_o, clock_output_pin_o;
	logic        interrupt_ack_out_n_o, ack_output_off_o;
	logic        host_bus_holder_en_o, data_bus_holder_en_o;
	int          error_cnt, checks_done, cyc_cnt;

	ebws_top u_ebws_top (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .req_i, .we_i, .space_i, .addr_i,
		.done_o, .busy_o, .ready_i, .ext_addr_o, .ext_we_o, .memory_strobe_n_o,
		.io_strobe_n_o, .clock_output_pin_o, .interrupt_ack_out_n_i, .interrupt_ack_out_n_o,
		.ack_output_off_o, .host_bus_holder_en_o, .data_bus_holder_en_o
	);

	ebws_mem_model u_ebws_mem_model (
		.clk_i(clk_i), .mem_sel_n_i(memory_strobe_n_o), .io_sel_n_i(io_strobe_n_o),
		.stall_i(stall), .ready_o(ready_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// a hang is cut short well past the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			final_report;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
			output logic [31:0] r);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= {16'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic acc(input ebws_space_t s, input logic [22:0] a, input logic w,
			output int n);
		n = 0;
		req_i   <= 1'b1;
		space_i <= s;
		addr_i  <= a;
		we_i    <= w;
		do begin
			@(posedge clk_i);
			n++;
		end while (done_o !== 1'b1);
		req_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic per(output int p);
		logic prev;
		int   k;
		p = 0;
		k = 0;
		prev = clock_output_pin_o;
		while (k < 2) begin
			@(posedge clk_i);
			if (k == 1)
				p++;
			if (!prev && clock_output_pin_o)
				k++;
			prev = clock_output_pin_o;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		int p;
		wb(0, 8'ha0, 16'h0, q);
		chk(q, 32'h7fff);
		wb(0, 8'ha4, 16'h0, q);
		chk(q, 32'hf000);
		wb(0, 8'hac, 16'h0, q);
		chk(q, 32'h0);
		chk({29'h0, ack_output_off_o, host_bus_holder_en_o, data_bus_holder_en_o}, 32'h4);
		per(p);
		chk(32'(p), 32'h4);
		$display("test reset done");
	endtask

	task automatic t_regs;
		wb(1, 8'ha0, 16'h1234, q);
		wb(0, 8'ha0, 16'h0, q);
		chk(q, 32'h1234);
		wb(1, 8'ha4, 16'hffff, q);
		wb(0, 8'ha4, 16'h0, q);
		chk(q, 32'hf006);
		chk({29'h0, ack_output_off_o, host_bus_holder_en_o, data_bus_holder_en_o}, 32'h7);
		wb(1, 8'hac, 16'hffff, q);
		wb(0, 8'hac, 16'h0, q);
		chk(q, 32'h1);
		wb(1, 8'hb0, 16'hffff, q);
		wb(0, 8'hb0, 16'h0, q);
		chk(q, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_div;
		int p;
		for (int d = 1; d < 4; d++) begin
			wb(1, 8'ha4, 16'(d << 13), q);
			per(p);
			per(p);
			chk(32'(p), 32'(d + 1));
		end
		$display("test divide done");
	endtask

	task automatic t_interrupt_ack_out;
		wb(1, 8'ha4, 16'h0, q);
		interrupt_ack_out_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({31'h0, interrupt_ack_out_n_o}, 32'h0);
		wb(1, 8'ha4, 16'h1000, q);
		chk({31'h0, interrupt_ack_out_n_o}, 32'h1);
		interrupt_ack_out_n_i <= 1'b1;
		$display("test interrupt_ack_out done");
	endtask

	task automatic t_wait;
		int nb, n1;
		wb(1, 8'ha4, 16'h0, q);
		wb(1, 8'hac, 16'h0, q);
		wb(1, 8'ha0, 16'h0, q);
		acc(SP_IO, 23'h10, 1'b0, nb);
		wb(1, 8'ha0, 16'h3000, q);
		acc(SP_IO, 23'h10, 1'b0, n1);
		chk(32'(n1 - nb), 32'h3);
		wb(1, 8'hac, 16'h1, q);
		acc(SP_IO, 23'h10, 1'b0, n1);
		chk(32'(n1 - nb), 32'h6);
		wb(1, 8'ha0, 16'h7000, q);
		acc(SP_IO, 23'hffff, 1'b1, n1);
		chk(32'(n1 - nb), 32'he);
		chk({8'h0, ext_we_o, ext_addr_o}, 32'h0080ffff);
		chk({29'h0, busy_o, memory_strobe_n_o, io_strobe_n_o}, 32'h3);
		wb(1, 8'hac, 16'h0, q);
		$display("test wait done");
	endtask

	task automatic t_data;
		int n0, n1, n2;
		wb(1, 8'ha0, 16'h0, q);
		acc(SP_DATA, 23'h2fff, 1'b0, n0);
		acc(SP_DATA, 23'h2fff, 1'b0, n0);
		wb(1, 8'ha0, 16'h0fc0, q);
		acc(SP_DATA, 23'h2fff, 1'b0, n2);
		chk(32'(n2), 32'(n0));
		acc(SP_DATA, 23'h3000, 1'b0, n1);
		chk(32'(n1 - n0), 32'h7);
		$display("test data done");
	endtask

	task automatic t_bank;
		int n0, n1;
		wb(1, 8'ha0, 16'h0, q);
		acc(SP_DATA, 23'h4000, 1'b0, n0);
		acc(SP_DATA, 23'h4000, 1'b0, n0);
		acc(SP_DATA, 23'h8000, 1'b0, n1);
		chk(32'(n1 - n0), 32'h1);
		acc(SP_DATA, 23'h8000, 1'b0, n1);
		chk(32'(n1), 32'(n0));
		acc(SP_PROG, 23'h8000, 1'b0, n1);
		chk(32'(n1 - n0), 32'h1);
		wb(1, 8'ha4, 16'h8000, q);
		acc(SP_PROG, 23'h8000, 1'b0, n1);
		chk(32'(n1 - n0), 32'h2);
		acc(SP_PROG, 23'h8000, 1'b1, n1);
		chk(32'(n1), 32'(n0));
		wb(1, 8'ha4, 16'h0, q);
		$display("test bank done");
	endtask

	task automatic t_prog;
		int n0, n1;
		wb(1, 8'ha0, 16'h0005, q);
		acc(SP_PROG, 23'h100, 1'b0, n1);
		acc(SP_PROG, 23'h100, 1'b0, n1);
		wb(1, 8'ha0, 16'h0, q);
		acc(SP_PROG, 23'h100, 1'b0, n0);
		chk(32'(n1 - n0), 32'h5);
		wb(1, 8'ha0, 16'h8028, q);
		acc(SP_PROG, 23'h400100, 1'b0, n1);
		acc(SP_PROG, 23'h400100, 1'b0, n1);
		chk(32'(n1 - n0), 32'h5);
		$display("test prog done");
	endtask

	task automatic t_ready;
		int n0, n1;
		wb(1, 8'ha0, 16'h0, q);
		acc(SP_IO, 23'h20, 1'b0, n0);
		stall <= 4'h6;
		// the ready synchroniser must see the stalled pin before the strobe
		repeat (3) @(posedge clk_i);
		acc(SP_IO, 23'h20, 1'b0, n1);
		stall <= 4'h0;
		chk({31'h0, n1 >= n0 + 6}, 32'h1);
		$display("test ready done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		req_i = 1'b0;
		we_i = 1'b0;
		space_i = SP_PROG;
		addr_i = 23'h0;
		interrupt_ack_out_n_i = 1'b1;
		stall = 4'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_regs;
		t_div;
		t_interrupt_ack_out;
		t_wait;
		t_data;
		t_bank;
		t_prog;
		t_ready;
		// a second reset in mid-run must bring every register back
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		final_report;
	end
endmodule
